/* File: core/adc_cfg_defines.svh */
// constants of the converter configuration register map
// included by the interface and the design modules; defines only
`ifndef ADC_CFG_DEFINES_SVH
`define ADC_CFG_DEFINES_SVH

`define ACFG_INSTR_BITS 16
`define ACFG_INSTR_LAST 4'hf
`define ACFG_BYTE_LAST 3'h7
`define ACFG_ADDR_W 13
`define ACFG_LEN_STREAM 2'h3

`define ACFG_CHIPCFG_LO 8'h00
`define ACFG_CHIPCFG_HI 8'h02
`define ACFG_FUNC_LO 8'h08
`define ACFG_FUNC_HI 8'ha8
`define ACFG_UPDATE 8'hff

`define ACFG_PORT_CFG 8'h00
`define ACFG_PORT_CFG_DEF 8'h18
`define ACFG_CHIP_ID 8'h01
`define ACFG_FORMAT 8'h14
`define ACFG_FORMAT_DEF 8'h01
`define ACFG_XFER_CMD 8'h01

`define ACFG_LSB_FIRST_BIT 6
`define ACFG_SOFT_RST_HI 5
`define ACFG_SOFT_RST_LO 2

`define ACFG_SHADOW_A 8'h09
`define ACFG_SHADOW_B 8'h0b
`define ACFG_SHADOW_C 8'h0d
`define ACFG_SHADOW_D 8'h10
`define ACFG_SHADOW_E 8'h18
`define ACFG_SHADOW_F 8'h21
`define ACFG_SHADOW_LO 8'h3a
`define ACFG_SHADOW_HI 8'h4c

`endif

/* File: core/adc_cfg_pkg.sv */
// types of the converter configuration register map
// no assumptions; pure type definitions
package adc_cfg_pkg;

  typedef logic [7:0] reg_byte_t;

  typedef enum logic [4:0] {
    st_idle = 5'b00001,
    st_instr = 5'b00010,
    st_wdata = 5'b00100,
    st_rdata = 5'b01000,
    st_hold = 5'b10000
  } serial_state_t;

endpackage

/* File: core/reg_access_if.sv */
// register access between the serial engine and the register store
// both ends run on the same clock
`timescale 1ns/10ps
`include "adc_cfg_defines.svh"

interface reg_access_if;
  logic [`ACFG_ADDR_W-1:0] addr;
  logic wr;
  logic [7:0] wr_data;
  logic [7:0] rd_data;
  logic [7:0] port_cfg;

  modport engine (output addr, output wr, output wr_data, input rd_data, input port_cfg);
  modport store (input addr, input wr, input wr_data, output rd_data, output port_cfg);
endinterface

/* File: core/reg_store.sv */
// byte-wide register store with shadow and active copies and the transfer bit
// assumes one write strobe per byte from the serial engine, same clock
`timescale 1ns/10ps
`include "adc_cfg_defines.svh"

module reg_store
  import adc_cfg_pkg::*;
#(
  parameter reg_byte_t CHIP_ID = 8'h5a
)
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  reg_access_if.store bus,
  output logic [7:0] active_format,
  output logic update_pulse
);

  function automatic logic is_supported(input logic [7:0] a);
    return (a <= `ACFG_CHIPCFG_HI) || (a >= `ACFG_FUNC_LO && a <= `ACFG_FUNC_HI);
  endfunction

  function automatic logic is_shadowed(input logic [7:0] a);
    return (a == `ACFG_SHADOW_A) || (a == `ACFG_SHADOW_B) || (a == `ACFG_SHADOW_C) ||
           (a == `ACFG_SHADOW_D) || (a == `ACFG_FORMAT) || (a == `ACFG_SHADOW_E) ||
           (a == `ACFG_SHADOW_F) || (a >= `ACFG_SHADOW_LO && a <= `ACFG_SHADOW_HI);
  endfunction

  function automatic reg_byte_t default_value(input logic [7:0] a);
    case (a)
      `ACFG_PORT_CFG: return `ACFG_PORT_CFG_DEF;
      `ACFG_FORMAT: return `ACFG_FORMAT_DEF;
      default: return 8'h00;
    endcase
  endfunction

  reg_byte_t held [256];
  reg_byte_t active [256];
  logic xfer_bit;
  logic in_map;
  logic soft_rst;

  assign in_map = (bus.addr[`ACFG_ADDR_W-1:8] == '0);
  // soft reset bits reload defaults, which also clears them
  assign soft_rst = held[`ACFG_PORT_CFG][`ACFG_SOFT_RST_HI] |
                    held[`ACFG_PORT_CFG][`ACFG_SOFT_RST_LO];
  assign bus.port_cfg = held[`ACFG_PORT_CFG];

  genvar i;
  generate
    for (i = 0; i < 256; i++)
    begin : g_entry
      localparam logic [7:0] A = 8'(i);
      if (is_supported(A) && A != `ACFG_CHIP_ID)
      begin : g_rw
        always_ff @(posedge clk or negedge resetn)
        begin
          if (!resetn)
            held[i] <= default_value(A); // [RQ6]
          else if (ce)
          begin
            if (soft_rst)
              held[i] <= default_value(A);
            else if (bus.wr && in_map && bus.addr[7:0] == A)
              held[i] <= bus.wr_data; // [RQ2] [RQ7] [RQ12]
          end
        end
        if (is_shadowed(A))
        begin : g_shadow
          always_ff @(posedge clk or negedge resetn)
          begin
            if (!resetn)
              active[i] <= default_value(A); // [RQ3]
            else if (ce)
            begin
              if (soft_rst)
                active[i] <= default_value(A);
              else if (xfer_bit)
                active[i] <= held[i]; // [RQ9]
            end
          end
        end
        else
        begin : g_direct
          assign active[i] = held[i]; // [RQ12]
        end
      end
      else
      begin : g_open
        assign held[i] = 8'h00;
        assign active[i] = 8'h00;
      end
    end
  endgenerate

  // set wins over the automatic clear
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      xfer_bit <= 1'b0;
    else if (ce)
    begin
      if (bus.wr && in_map && bus.addr[7:0] == `ACFG_UPDATE && bus.wr_data == `ACFG_XFER_CMD)
        xfer_bit <= 1'b1; // [RQ8]
      else if (xfer_bit)
        xfer_bit <= 1'b0; // [RQ10]
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      update_pulse <= 1'b0;
    else if (ce)
      update_pulse <= xfer_bit;
  end

  assign active_format = active[`ACFG_FORMAT];

  // [RQ1] [RQ12]
  always_comb
  begin
    bus.rd_data = 8'h00;
    if (in_map)
    begin
      case (bus.addr[7:0])
        `ACFG_CHIP_ID: bus.rd_data = CHIP_ID;
        `ACFG_UPDATE: bus.rd_data = {7'h00, xfer_bit};
        default: bus.rd_data = held[bus.addr[7:0]];
      endcase
    end
  end

endmodule

/* File: core/adc_config_register_map.sv */
// serial configuration port and register map of a high-speed converter
// assumes serial pins synchronous to clk and sclk slower than clk / 4
// How it works
// RQ1 - addresses 0x00-0x02, 0x08-0xa8 and 0xff are the mapped regions.
// RQ2 - every register is one byte with bit 7 as its most significant bit.
// RQ3 - the output format register at 0x14 resets to 0x01, twos complement.
// RQ4 - the host writes zeros into unused bits of a supported register.
// RQ5 - the host never writes an address that is wholly unsupported.
// RQ6 - reset loads every register with its default value.
// RQ7 - writes to shadowed registers are held until a transfer is commanded.
// RQ8 - writing 0x01 to 0xff sets the transfer bit.
// RQ9 - a set transfer bit copies all shadowed values to the active copies at once.
// RQ10 - the transfer bit clears itself after the update.
// RQ11 - a frame is a 16-bit instruction followed by 8-bit data words.
// RQ12 - plain registers act at once; unsupported reads give zero, writes do nothing.
`timescale 1ns/10ps
`include "adc_cfg_defines.svh"

module adc_config_register_map
  import adc_cfg_pkg::*;
#(
  parameter reg_byte_t CHIP_ID = 8'h5a
)
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic sdio_in,
  output logic sdio_out,
  output logic sdio_oe_n,
  output logic [7:0] output_format,
  output logic update_done
);

  reg_access_if ra ();

  serial_state_t state;
  logic sclk_d;
  logic sclk_rise;
  logic sclk_fall;
  logic [3:0] bit_cnt;
  logic [`ACFG_INSTR_BITS-2:0] instr_sr;
  logic [7:0] data_sr;
  logic [7:0] rd_sr;
  logic [7:0] next_byte;
  logic [1:0] bytes_left;
  logic stream;
  logic load_pend;
  logic lsb_first;
  logic byte_done;
  logic last_byte;
  logic [`ACFG_ADDR_W-1:0] addr;
  logic wr;
  logic [7:0] wr_data;

  assign sclk_rise = sclk & ~sclk_d;
  assign sclk_fall = ~sclk & sclk_d;
  assign lsb_first = ra.port_cfg[`ACFG_LSB_FIRST_BIT];
  assign next_byte = lsb_first ? {sdio_in, data_sr[7:1]} : {data_sr[6:0], sdio_in};
  assign byte_done = sclk_rise && bit_cnt[2:0] == `ACFG_BYTE_LAST;
  assign last_byte = !stream && bytes_left == 2'h0;

  assign ra.addr = addr;
  assign ra.wr = wr;
  assign ra.wr_data = wr_data;

  reg_store #(
    .CHIP_ID(CHIP_ID)
  ) u_store (
    .clk(clk),
    .resetn(resetn),
    .ce(ce),
    .bus(ra),
    .active_format(output_format),
    .update_pulse(update_done)
  );

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      sclk_d <= 1'b0;
    else if (ce)
      sclk_d <= sclk;
  end

  // frame sequencing; chip select high always ends the frame
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state <= st_idle;
      bit_cnt <= 4'h0;
    end
    else if (ce)
    begin
      if (cs_n)
      begin
        state <= st_idle;
        bit_cnt <= 4'h0;
      end
      else
      begin
        case (state)
          st_idle:
          begin
            state <= st_instr;
            bit_cnt <= 4'h0;
          end
          st_instr:
          begin
            if (sclk_rise)
            begin
              bit_cnt <= bit_cnt + 4'h1;
              if (bit_cnt == `ACFG_INSTR_LAST)
              begin
                state <= instr_sr[`ACFG_INSTR_BITS-2] ? st_rdata : st_wdata; // [RQ11]
                bit_cnt <= 4'h0;
              end
            end
          end
          st_wdata, st_rdata:
          begin
            if (sclk_rise)
              bit_cnt <= {1'b0, bit_cnt[2:0] + 3'h1};
            if (byte_done && last_byte)
              state <= st_hold;
          end
          st_hold:
            state <= st_hold;
          default:
            state <= st_idle;
        endcase
      end
    end
  end

  // instruction word: rw, two length bits, thirteen address bits
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      instr_sr <= '0;
    else if (ce && state == st_instr && sclk_rise)
      instr_sr <= {instr_sr[`ACFG_INSTR_BITS-3:0], sdio_in}; // [RQ11]
  end

  // byte count from the length field; all ones streams until deselect
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      bytes_left <= 2'h0;
      stream <= 1'b0;
    end
    else if (ce)
    begin
      if (state == st_instr && sclk_rise && bit_cnt == `ACFG_INSTR_LAST)
      begin
        bytes_left <= instr_sr[`ACFG_INSTR_BITS-3:`ACFG_INSTR_BITS-4];
        stream <= instr_sr[`ACFG_INSTR_BITS-3:`ACFG_INSTR_BITS-4] == `ACFG_LEN_STREAM;
      end
      else if ((state == st_wdata || state == st_rdata) && byte_done && bytes_left != 2'h0)
        bytes_left <= bytes_left - 2'h1;
    end
  end

  // address comes from the instruction, then steps once per byte
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      addr <= '0;
    else if (ce)
    begin
      if (state == st_instr && sclk_rise && bit_cnt == `ACFG_INSTR_LAST)
        addr <= {instr_sr[`ACFG_ADDR_W-2:0], sdio_in};
      // a written byte steps the address only once its strobe has used it
      else if ((state == st_rdata && byte_done) || wr)
        addr <= addr + `ACFG_ADDR_W'(1);
    end
  end

  // write path: one strobe per assembled byte
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      data_sr <= 8'h00;
      wr <= 1'b0;
      wr_data <= 8'h00;
    end
    else if (ce)
    begin
      wr <= 1'b0;
      if (state == st_wdata && sclk_rise)
      begin
        data_sr <= next_byte;
        if (bit_cnt[2:0] == `ACFG_BYTE_LAST)
        begin
          wr <= 1'b1; // [RQ11]
          wr_data <= next_byte; // [RQ2]
        end
      end
    end
  end

  // read path: fetch one clock after the address settles, shift on falling sclk
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      load_pend <= 1'b0;
    else if (ce)
    begin
      if (cs_n)
        load_pend <= 1'b0;
      else if (state == st_instr && sclk_rise && bit_cnt == `ACFG_INSTR_LAST)
        load_pend <= instr_sr[`ACFG_INSTR_BITS-2];
      else if (state == st_rdata && byte_done && !last_byte)
        load_pend <= 1'b1;
      else
        load_pend <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rd_sr <= 8'h00;
      sdio_out <= 1'b0;
    end
    else if (ce)
    begin
      if (load_pend)
        rd_sr <= ra.rd_data; // [RQ12]
      else if (state == st_rdata && sclk_fall)
      begin
        sdio_out <= lsb_first ? rd_sr[0] : rd_sr[7];
        rd_sr <= lsb_first ? {1'b0, rd_sr[7:1]} : {rd_sr[6:0], 1'b0};
      end
    end
  end

  // pin turns round only once a read byte starts shifting
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      sdio_oe_n <= 1'b1;
    else if (ce)
    begin
      if (cs_n || state != st_rdata)
        sdio_oe_n <= 1'b1;
      else if (sclk_fall)
        sdio_oe_n <= 1'b0;
    end
  end

endmodule

/* File: core/README_unused.sv */
// spare design-side file; holds no logic

/* File: bench/adc_cfg_properties.sv */
// assertions on the serial pins and the active format output
// bound to the register map top; one clock, async active-low reset
`timescale 1ns/10ps

module adc_cfg_properties
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic sdio_in,
  input wire logic sdio_out,
  input wire logic sdio_oe_n,
  input wire logic [7:0] output_format,
  input wire logic update_done
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  reset_vals_a:
    assert property (!$past(resetn) |-> output_format == 8'h01 && !update_done && sdio_oe_n)
    else $error("reset values wrong");
  fmt_hold_a:
    assert property ($changed(output_format) |-> update_done || output_format == 8'h01)
    else $error("format changed without transfer");
  done_pulse_a:
    assert property (update_done |=> !update_done)
    else $error("transfer bit not cleared");
  done_after_rise_a:
    assert property ($rose(update_done) |-> $past(sclk, 3) && !$past(sclk, 4))
    else $error("update not three cycles after last bit");
  idle_quiet_a:
    assert property (cs_n [*5] |-> !update_done)
    else $error("update outside a frame");
  oe_release_a:
    assert property (cs_n |=> sdio_oe_n)
    else $error("drive kept after deselect");
  oe_fall_a:
    assert property ($fell(sdio_oe_n) |-> $past(sclk, 2) && !$past(sclk))
    else $error("drive start not after clock fall");
  out_timing_a:
    assert property (!sdio_oe_n && $changed(sdio_out) |-> $past(sclk, 2) && !$past(sclk))
    else $error("read bit changed off the clock fall");
endmodule

bind adc_config_register_map adc_cfg_properties u_props (.clk(clk), .resetn(resetn), .ce(ce),
  .sclk(sclk), .cs_n(cs_n), .sdio_in(sdio_in), .sdio_out(sdio_out), .sdio_oe_n(sdio_oe_n),
  .output_format(output_format), .update_done(update_done));

/* File: bench/adc_host_model.sv */
// serial host: one frame is a 16-bit instruction and one data byte
// runs off the bench clock; pins change on its falling edge
`timescale 1ns/10ps

module adc_host_model
(
  input wire logic clk,
  output logic sclk,
  output logic cs_n,
  output wire logic sdio_line,
  input wire logic sdio_out,
  input wire logic sdio_oe_n
);
  logic drv;

  initial
  begin
    sclk = 1'b0;
    cs_n = 1'b1;
    drv = 1'b0;
  end

  // wire level: host drive unless the device output enable is active
  assign sdio_line = sdio_oe_n ? drv : sdio_out;

  task automatic xfer(input logic rd, input logic [12:0] a, input logic [7:0] wd,
    output logic [7:0] rv);
    logic [23:0] f;
    f = {rd, 2'b00, a, wd};
    @(negedge clk);
    cs_n = 1'b0;
    repeat (2) @(negedge clk);
    for (int i = 23; i >= 0; i--)
    begin
      // released during read data: inverse of last value
      drv = (rd && i < 8) ? ~drv : f[i];
      repeat (4) @(negedge clk);
      sclk = 1'b1;
      rv[i % 8] = sdio_line;
      repeat (4) @(negedge clk);
      sclk = 1'b0;
    end
    repeat (4) @(negedge clk);
    cs_n = 1'b1;
    drv = ~drv;
    repeat (3) @(negedge clk);
  endtask
endmodule

/* File: bench/tb_adc_config_register_map.sv */
// self-checking bench of the converter register map
// host model drives the serial pins; a map of integers predicts every read
`timescale 1ns/10ps

module tb_adc_config_register_map
  import adc_cfg_pkg::*;
;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic ce = 1'b1;
  logic sclk, cs_n, sdio_line, sdio_out, sdio_oe_n, update_done;
  logic [7:0] output_format;
  int err_count = 0;
  int n_tests = 0;
  int n_upd = 0;
  int mdl[int];
  logic [15:0] seed = 16'h05ed;
  reg_byte_t rv, fmt;
  logic [12:0] ra[] = '{13'h0, 13'h2, 13'h3, 13'h7, 13'h8, 13'h14, 13'ha8, 13'ha9, 13'hfe,
    13'hff, 13'h100};
  logic [12:0] wa[] = '{13'h2, 13'h8, 13'ha8, 13'h9, 13'hb, 13'hd, 13'h10, 13'h14, 13'h18,
    13'h21, 13'h3a, 13'h4c};

  always #2 clk = ~clk;

  always @(posedge clk)
    if (update_done === 1'b1) n_upd++;

  adc_config_register_map DUT (.clk(clk), .resetn(resetn), .ce(ce), .sclk(sclk), .cs_n(cs_n),
    .sdio_in(sdio_line), .sdio_out(sdio_out), .sdio_oe_n(sdio_oe_n),
    .output_format(output_format), .update_done(update_done));
  adc_host_model host (.clk(clk), .sclk(sclk), .cs_n(cs_n), .sdio_line(sdio_line),
    .sdio_out(sdio_out), .sdio_oe_n(sdio_oe_n));

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  function automatic bit mapped(input logic [12:0] a);
    return a <= 13'h2 || (a >= 13'h8 && a <= 13'ha8) || a == 13'hff;
  endfunction

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  function automatic reg_byte_t rev8(input reg_byte_t v);
    reg_byte_t r;
    for (int k = 0; k < 8; k++)
      r[k] = v[7 - k];
    return r;
  endfunction

  task automatic load_defaults;
    mdl.delete();
    mdl[0] = 8'h18;
    mdl[20] = 8'h01;
    fmt = 8'h01;
  endtask

  task automatic do_reset;
    resetn = 1'b0;
    repeat (12) @(negedge clk);
    resetn = 1'b1;
    load_defaults();
    repeat (2) @(negedge clk);
  endtask

  // data bytes arrive bit-reversed while the port is in lsb-first mode
  task automatic wr(input logic [12:0] a, input reg_byte_t d);
    reg_byte_t s;
    s = mdl[0][6] ? rev8(d) : d;
    host.xfer(1'b0, a, d, rv);
    if (a == 13'h0 && (s[5] || s[2]))
      load_defaults();
    else if (a != 13'hff)
      mdl[a] = s;
    else if (s == 8'h01)
      fmt = 8'(mdl[20]);
  endtask

  task automatic rd(input logic [12:0] a);
    reg_byte_t e;
    e = (mapped(a) && mdl.exists(a)) ? 8'(mdl[a]) : 8'h00;
    host.xfer(1'b1, a, 8'h00, rv);
    check("read", rv, mdl[0][6] ? rev8(e) : e);
  endtask

  task automatic summarize;
    $display("tests %0d errors %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial
  begin
    repeat (60000) @(posedge clk);
    err_count++;
    summarize();
  end

  initial
  begin
    do_reset();
    check("fmt", output_format, fmt);
    foreach (ra[i])
      rd(ra[i]);
    foreach (wa[i])
    begin
      seed = lfsr(seed);
      wr(wa[i], seed[7:0]);
    end
    foreach (wa[i])
      rd(wa[i]);
    check("fmt", output_format, fmt);
    wr(13'hff, 8'h02);
    check("upd", 8'(n_upd), 8'h00);
    wr(13'hff, 8'h01);
    check("fmt", output_format, fmt);
    check("upd", 8'(n_upd), 8'h01);
    rd(13'hff);
    seed = lfsr(seed);
    wr(13'h14, seed[7:0]);
    wr(13'hff, 8'h01);
    check("fmt", output_format, fmt);
    // frame sent with the clock enable low must leave the map untouched
    ce = 1'b0;
    host.xfer(1'b0, 13'h2, 8'(~mdl[2]), rv);
    ce = 1'b1;
    rd(13'h2);
    // lsb-first data bytes, then back to msb-first
    wr(13'h0, 8'h58);
    wr(13'h2, 8'h0c);
    rd(13'h2);
    wr(13'h0, 8'h18);
    rd(13'h2);
    // soft reset bits reload the whole map
    wr(13'h0, 8'h3c);
    check("fmt", output_format, fmt);
    rd(13'h2);
    rd(13'h0);
    do_reset();
    check("fmt", output_format, fmt);
    rd(13'h14);
    summarize();
  end
endmodule
